/* dio_pkg.sv */
// Constants shared by the isolated digital I/O controller.
// Assumes a single core clock domain and an AXI4-Lite register bus.
package dio_pkg;
    localparam int          CMD_W           = 16;
    localparam int          DATA_W          = 16;
    localparam int          IRQ_W           = 3;

    // Register byte offsets
    localparam logic [7:0]  OFS_STATUS_CMD  = 8'h00;
    localparam logic [7:0]  OFS_DATA_CLEAR  = 8'h04;
    localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h08;
    localparam logic [7:0]  OFS_IRQ_MASK    = 8'h0C;

    // Status byte bit positions
    localparam int          ST_CMD_READY    = 0;
    localparam int          ST_DATA_AVAIL   = 1;
    localparam int          ST_DATA_EMPTY   = 2;
    localparam int          ST_CONV_BUSY    = 3;
    localparam int          ST_DATA_HALF    = 4;
    localparam int          ST_DATA_FULL    = 5;

    // Interrupt status bit positions
    localparam int          IRQ_LATCH       = 0;
    localparam int          IRQ_DATA        = 1;
    localparam int          IRQ_CMD_OVF     = 2;

    // Reset values
    localparam logic [7:0]  POLARITY_RST    = 8'h00;
    localparam logic [6:0]  OUTPUT_RST      = 7'h00;
    localparam logic [7:0]  LATCH_RST       = 8'h00;
    localparam logic [2:0]  IRQ_RST         = 3'h0;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // Command opcodes, carried in bits 15:8 of a command word
    typedef enum logic [7:0] {
        OP_SET_POLARITY = 8'h01,
        OP_GET_POLARITY = 8'h02,
        OP_SET_OUTPUT   = 8'h03,
        OP_GET_OUTPUT   = 8'h04,
        OP_GET_RAW      = 8'h05,
        OP_GET_LATCH    = 8'h06,
        OP_CLR_LATCH    = 8'h07
    } cmd_op_e;
endpackage

/* dio_ctrl.sv */
// Isolated digital I/O controller: command and data queues, input latches,
// open-collector outputs, status byte and interrupt, behind AXI4-Lite.
// Assumes isolated inputs and converter busy arrive asynchronously.
//
// Summary of operation
// [RQ1] Eight-bit polarity; one means active low
// [RQ2] Polarity read returns stored setting unchanged
// [RQ3] Bits 0-6 drive seven open-collector outputs
// [RQ4] Output read returns last stored output value
// [RQ5] Raw read returns inputs without polarity
// [RQ6] Latched read returns polarity-applied latch bits
// [RQ7] Clear mask: zero clears, one keeps
// [RQ8] Status: cmd ready, data, empty, busy
// [RQ9] Base: read status, write queues command
// [RQ10] Base+4: read pops data, write flushes both
// [RQ11] Latch sets on active level, holds until cleared
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module sync_word_fifo #(
    parameter int W  = 16,
    parameter int AW = 4
) (
    input  wire logic          core_clk,
    input  wire logic          rstn,
    input  wire logic          flush,
    input  wire logic          push,
    input  wire logic [W-1:0]  push_data,
    input  wire logic          pop,
    output logic      [W-1:0]  head,
    output logic               full,
    output logic               empty,
    output logic               half
);
    logic [W-1:0]  mem [2**AW];
    logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
    logic [AW:0]   cnt_ff, nxt_cnt;
    logic          do_push, do_pop;

    always_comb begin
        do_push = push && !full && !flush;
        do_pop  = pop && !empty && !flush;
        nxt_wp  = flush ? '0 : wp_ff + AW'(do_push);
        nxt_rp  = flush ? '0 : rp_ff + AW'(do_pop);
        nxt_cnt = flush ? '0 : cnt_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wp_ff  <= nxt_wp;
            rp_ff  <= nxt_rp;
            cnt_ff <= nxt_cnt;
        end
    end

    // Storage carries no reset; only pointers define contents
    always_ff @(posedge core_clk) begin
        if (do_push) begin
            mem[wp_ff] <= push_data;
        end
    end

    assign head  = mem[rp_ff];
    assign full  = cnt_ff[AW];
    assign empty = (cnt_ff == '0);
    assign half  = (cnt_ff >= (AW+1)'(2**(AW-1)));
endmodule

////////////////////////////////////////////////////////////////////////////////
module dio_ctrl #(
    parameter int CMD_AW  = 4,
    parameter int DATA_AW = 4
) (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  isolated_input,
    input  wire logic        conv_busy,
    output logic      [6:0]  oc_on,
    output logic             irq
);
    function automatic logic hits(input logic [7:0] a, input logic [7:0] ofs);
        return a[7:2] == ofs[7:2];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [7:0] in_meta_ff, in_sync_ff;
    logic       busy_meta_ff, busy_sync_ff;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            in_meta_ff   <= 8'h00;
            in_sync_ff   <= 8'h00;
            busy_meta_ff <= 1'b0;
            busy_sync_ff <= 1'b0;
        end else begin
            in_meta_ff   <= isolated_input;
            in_sync_ff   <= in_meta_ff;
            busy_meta_ff <= conv_busy;
            busy_sync_ff <= busy_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Queues
    logic [15:0] cmd_head, data_head, push_word, s_wdata_lo;
    logic        cmd_full, cmd_empty, data_full, data_empty, data_half;
    logic        cmd_push, cmd_pop, data_push, data_pop, flush;

    sync_word_fifo #(.W(dio_pkg::CMD_W), .AW(CMD_AW)) u_cmd_fifo (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .flush     (flush),
        .push      (cmd_push),
        .push_data (s_wdata_lo),
        .pop       (cmd_pop),
        .head      (cmd_head),
        .full      (cmd_full),
        .empty     (cmd_empty),
        .half      ()
    );

    sync_word_fifo #(.W(dio_pkg::DATA_W), .AW(DATA_AW)) u_data_fifo (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .flush     (flush),
        .push      (data_push),
        .push_data (push_word),
        .pop       (data_pop),
        .head      (data_head),
        .full      (data_full),
        .empty     (data_empty),
        .half      (data_half)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Command executer: one command per cycle, stalls while the data queue is full
    logic [7:0] polarity_ff, nxt_polarity, latch_ff, nxt_latch, active, keep;
    logic [6:0] oc_on_ff, nxt_oc_on;
    logic       exec;
    logic [7:0] arg;

    always_comb begin
        exec         = !cmd_empty && !data_full;
        cmd_pop      = exec;
        arg          = cmd_head[7:0];
        nxt_polarity = polarity_ff;
        nxt_oc_on    = oc_on_ff;
        keep         = 8'hFF;
        data_push    = 1'b0;
        push_word    = 16'h0000;
        active       = in_sync_ff ^ polarity_ff;                         // [RQ1]
        if (exec) begin
            case (cmd_head[15:8])
                dio_pkg::OP_SET_POLARITY: nxt_polarity = arg;            // [RQ1]
                dio_pkg::OP_GET_POLARITY: begin
                    data_push = 1'b1;
                    push_word = {8'h00, polarity_ff};                    // [RQ2]
                end
                dio_pkg::OP_SET_OUTPUT:   nxt_oc_on = arg[6:0];          // [RQ3]
                dio_pkg::OP_GET_OUTPUT: begin
                    data_push = 1'b1;
                    push_word = {9'h000, oc_on_ff};                      // [RQ4]
                end
                dio_pkg::OP_GET_RAW: begin
                    data_push = 1'b1;
                    push_word = {8'h00, in_sync_ff};                     // [RQ5]
                end
                dio_pkg::OP_GET_LATCH: begin
                    data_push = 1'b1;
                    push_word = {8'h00, latch_ff};                       // [RQ6]
                end
                dio_pkg::OP_CLR_LATCH:    keep = arg;                    // [RQ7]
                default:                  keep = 8'hFF;
            endcase
        end
        // A channel that is active in the clearing cycle stays latched
        nxt_latch = (latch_ff & keep) | active;                          // [RQ11]
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            polarity_ff <= dio_pkg::POLARITY_RST;
            oc_on_ff    <= dio_pkg::OUTPUT_RST;
            latch_ff    <= dio_pkg::LATCH_RST;
        end else begin
            polarity_ff <= nxt_polarity;
            oc_on_ff    <= nxt_oc_on;
            latch_ff    <= nxt_latch;
        end
    end

    assign oc_on = oc_on_ff;                                             // [RQ3]

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave, one write and one read in flight
    logic        aw_held_ff, w_held_ff, bvalid_ff, awready_ff, wready_ff;
    logic        nxt_aw_held, nxt_w_held, nxt_bvalid, do_write;
    logic [7:0]  awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
    logic [3:0]  wstrb_ff, nxt_wstrb;
    logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic        rvalid_ff, nxt_rvalid, arready_ff, do_read;
    logic [7:0]  status_byte;
    logic [2:0]  irq_stat_ff, nxt_irq_stat, irq_mask_ff, nxt_irq_mask, events;
    logic        irq_ff, nxt_irq, irq_rd;

    assign s_wdata_lo = wdata_ff[15:0];

    always_comb begin
        status_byte = 8'h00;
        status_byte[dio_pkg::ST_CMD_READY]  = !cmd_full;                 // [RQ8]
        status_byte[dio_pkg::ST_DATA_AVAIL] = !data_empty;               // [RQ8]
        status_byte[dio_pkg::ST_DATA_EMPTY] = data_empty;                // [RQ8]
        status_byte[dio_pkg::ST_CONV_BUSY]  = busy_sync_ff;              // [RQ8]
        status_byte[dio_pkg::ST_DATA_HALF]  = data_half;
        status_byte[dio_pkg::ST_DATA_FULL]  = data_full;
    end

    always_comb begin
        nxt_aw_held  = aw_held_ff || (s_axi_awvalid && awready_ff);
        nxt_w_held   = w_held_ff || (s_axi_wvalid && wready_ff);
        nxt_awaddr   = (s_axi_awvalid && awready_ff) ? s_axi_awaddr : awaddr_ff;
        nxt_wdata    = (s_axi_wvalid && wready_ff) ? s_axi_wdata : wdata_ff;
        nxt_wstrb    = (s_axi_wvalid && wready_ff) ? s_axi_wstrb : wstrb_ff;
        do_write     = aw_held_ff && w_held_ff && !bvalid_ff;
        nxt_bvalid   = bvalid_ff && !s_axi_bready;
        nxt_bresp    = bresp_ff;
        nxt_irq_mask = irq_mask_ff;
        cmd_push     = 1'b0;
        flush        = 1'b0;
        events       = 3'h0;
        if (do_write) begin
            nxt_aw_held = 1'b0;
            nxt_w_held  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = dio_pkg::RESP_OKAY;
            if (hits(awaddr_ff, dio_pkg::OFS_STATUS_CMD)) begin
                // A command that finds the queue full is dropped and flagged
                cmd_push = |wstrb_ff[1:0] && !cmd_full;                  // [RQ9]
                events[dio_pkg::IRQ_CMD_OVF] = |wstrb_ff[1:0] && cmd_full;
            end else if (hits(awaddr_ff, dio_pkg::OFS_DATA_CLEAR)) begin
                flush = 1'b1;                                            // [RQ10]
            end else if (hits(awaddr_ff, dio_pkg::OFS_IRQ_MASK)) begin
                if (wstrb_ff[0]) nxt_irq_mask = wdata_ff[2:0];
            end else if (!hits(awaddr_ff, dio_pkg::OFS_IRQ_STATUS)) begin
                nxt_bresp = dio_pkg::RESP_SLVERR;
            end
        end
        events[dio_pkg::IRQ_LATCH] = |(active & ~latch_ff);
        events[dio_pkg::IRQ_DATA]  = data_push && !flush;
    end

    always_comb begin
        do_read    = s_axi_arvalid && arready_ff;
        nxt_rvalid = (rvalid_ff && !s_axi_rready) || do_read;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        data_pop   = 1'b0;
        irq_rd     = 1'b0;
        if (do_read) begin
            nxt_rresp = dio_pkg::RESP_OKAY;
            nxt_rdata = 32'h0000_0000;
            if (hits(s_axi_araddr, dio_pkg::OFS_STATUS_CMD)) begin
                nxt_rdata = {24'h00_0000, status_byte};                  // [RQ9]
            end else if (hits(s_axi_araddr, dio_pkg::OFS_DATA_CLEAR)) begin
                // An empty queue reads as zero and is not disturbed
                nxt_rdata = {16'h0000, data_empty ? 16'h0000 : data_head};
                data_pop  = 1'b1;                                        // [RQ10]
            end else if (hits(s_axi_araddr, dio_pkg::OFS_IRQ_STATUS)) begin
                nxt_rdata = {29'h0000_0000, irq_stat_ff};
                irq_rd    = 1'b1;
            end else if (hits(s_axi_araddr, dio_pkg::OFS_IRQ_MASK)) begin
                nxt_rdata = {29'h0000_0000, irq_mask_ff};
            end else begin
                nxt_rresp = dio_pkg::RESP_SLVERR;
            end
        end
        // New events win over the read that clears
        nxt_irq_stat = (irq_rd ? 3'h0 : irq_stat_ff) | events;
        nxt_irq      = |(nxt_irq_stat & nxt_irq_mask);
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            aw_held_ff  <= 1'b0;
            w_held_ff   <= 1'b0;
            awready_ff  <= 1'b0;
            wready_ff   <= 1'b0;
            awaddr_ff   <= 8'h00;
            wdata_ff    <= 32'h0000_0000;
            wstrb_ff    <= 4'h0;
            bvalid_ff   <= 1'b0;
            bresp_ff    <= dio_pkg::RESP_OKAY;
            arready_ff  <= 1'b0;
            rvalid_ff   <= 1'b0;
            rdata_ff    <= 32'h0000_0000;
            rresp_ff    <= dio_pkg::RESP_OKAY;
            irq_stat_ff <= dio_pkg::IRQ_RST;
            irq_mask_ff <= dio_pkg::IRQ_RST;
            irq_ff      <= 1'b0;
        end else begin
            aw_held_ff  <= nxt_aw_held;
            w_held_ff   <= nxt_w_held;
            awready_ff  <= !nxt_aw_held;
            wready_ff   <= !nxt_w_held;
            awaddr_ff   <= nxt_awaddr;
            wdata_ff    <= nxt_wdata;
            wstrb_ff    <= nxt_wstrb;
            bvalid_ff   <= nxt_bvalid;
            bresp_ff    <= nxt_bresp;
            arready_ff  <= !nxt_rvalid;
            rvalid_ff   <= nxt_rvalid;
            rdata_ff    <= nxt_rdata;
            rresp_ff    <= nxt_rresp;
            irq_stat_ff <= nxt_irq_stat;
            irq_mask_ff <= nxt_irq_mask;
            irq_ff      <= nxt_irq;
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign irq           = irq_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    property p_latch_set;
        (active & ~latch_ff) != 8'h00 |=> (latch_ff & $past(active)) == $past(active);
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("latch missed active level"); // [RQ11]

    property p_latch_clear;
        exec && cmd_head[15:8] == dio_pkg::OP_CLR_LATCH
            |=> (latch_ff & ~$past(arg) & ~$past(active)) == 8'h00;
    endproperty
    a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared"); // [RQ7]

    property p_polarity_read;
        exec && !flush && cmd_head[15:8] == dio_pkg::OP_GET_POLARITY
            |-> data_push && push_word[7:0] == polarity_ff ##1 !data_empty;
    endproperty
    a_polarity_read: assert property (p_polarity_read) else $error("polarity read lost"); // [RQ2]

    property p_polarity_write;
        exec && cmd_head[15:8] == dio_pkg::OP_SET_POLARITY |=> polarity_ff == $past(arg);
    endproperty
    a_polarity_write: assert property (p_polarity_write) else $error("polarity not stored"); // [RQ1]

    property p_output_write;
        exec && cmd_head[15:8] == dio_pkg::OP_SET_OUTPUT |=> oc_on == 7'($past(arg));
    endproperty
    a_output_write: assert property (p_output_write) else $error("output not driven"); // [RQ3]

    property p_output_read;
        exec && cmd_head[15:8] == dio_pkg::OP_GET_OUTPUT |-> push_word[6:0] == oc_on;
    endproperty
    a_output_read: assert property (p_output_read) else $error("output readback wrong"); // [RQ4]

    property p_raw_read;
        exec && cmd_head[15:8] == dio_pkg::OP_GET_RAW |-> push_word[7:0] == in_sync_ff;
    endproperty
    a_raw_read: assert property (p_raw_read) else $error("raw read wrong"); // [RQ5]

    property p_latch_read;
        exec && cmd_head[15:8] == dio_pkg::OP_GET_LATCH |-> push_word[7:0] == latch_ff;
    endproperty
    a_latch_read: assert property (p_latch_read) else $error("latch read wrong"); // [RQ6]

    property p_status_read;
        do_read && hits(s_axi_araddr, dio_pkg::OFS_STATUS_CMD)
            |=> s_axi_rvalid && s_axi_rdata[3:0] == {$past(busy_sync_ff), $past(data_empty),
                !$past(data_empty), !$past(cmd_full)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status byte wrong"); // [RQ8]

    property p_cmd_enqueue;
        cmd_push |=> !cmd_empty;
    endproperty
    a_cmd_enqueue: assert property (p_cmd_enqueue) else $error("command not queued"); // [RQ9]

    property p_flush;
        do_write && hits(awaddr_ff, dio_pkg::OFS_DATA_CLEAR) |=> data_empty && cmd_empty && s_axi_bvalid;
    endproperty
    a_flush: assert property (p_flush) else $error("queues not flushed"); // [RQ10]
endmodule

`default_nettype wire

/* dio_field.sv */
// Field-side model: isolated input wiring and the converter busy line.
// Assumes the bench asks for levels; they reach the pins at a clock edge.
`timescale 1ns/1ps
`default_nettype none
module dio_field (
    input  wire logic       core_clk,
    input  wire logic [7:0] want_level,
    input  wire logic       want_busy,
    output logic      [7:0] isolated_input,
    output logic            conv_busy
);
    // Pins start defined so the synchronisers never see an unknown
    initial begin
        isolated_input = 8'h00;
        conv_busy = 1'b0;
    end
    always @(posedge core_clk) begin
        isolated_input <= want_level;
        conv_busy <= want_busy;
    end
endmodule
`default_nettype wire

/* dio_ctrl_tb.sv */
// Self-checking bench for dio_ctrl over AXI4-Lite with a field-side model.
// Assumes 40 MHz core clock, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module dio_ctrl_tb;
    logic core_clk, rstn, irq, busy_w;
    logic [7:0] s_axi_awaddr, s_axi_araddr, lvl, iso_in, p, x, m;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, conv_busy;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [6:0] oc_on;
    logic [33:0] exp_q[$];
    int bad_count, cmp_count;
    dio_ctrl u_dut (.core_clk(core_clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .isolated_input(iso_in), .conv_busy(conv_busy),
        .oc_on(oc_on), .irq(irq));
    dio_field u_field (.core_clk(core_clk), .want_level(lvl), .want_busy(busy_w),
        .isolated_input(iso_in), .conv_busy(conv_busy));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic chk(input string what, input logic [33:0] e, input logic [33:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Address and data are offered together and released one by one as taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge core_clk);
            if (!ta && s_axi_awready) begin
                ta = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!tw && s_axi_wready) begin
                tw = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
        chk("bresp", {32'h0, r}, {32'h0, s_axi_bresp});
    endtask
    // Expected answer is queued here and judged by the read monitor
    task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
        exp_q.push_back({r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge core_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    endtask
    task automatic cmd(input dio_pkg::cmd_op_e op, input logic [7:0] arg);
        wr(dio_pkg::OFS_STATUS_CMD, {16'h0000, op, arg}, dio_pkg::RESP_OKAY);
        repeat (3) @(posedge core_clk);
    endtask
    task automatic settle(input logic [7:0] v);
        lvl <= v;
        repeat (5) @(posedge core_clk);
    endtask
    function automatic logic [31:0] st(input logic avail, input logic bsy);
        return {28'h0000000, bsy, ~avail, avail, 1'b1};
    endfunction
    always @(posedge core_clk) begin
        if (rstn && s_axi_rvalid && s_axi_rready && exp_q.size() > 0)
            chk("rdata", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
    end
    // Whole run is a few hundred cycles; the span leaves wide margin
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        test_done();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        bad_count = 0;
        cmp_count = 0;
        {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hF;
        lvl = 8'h00;
        busy_w = 1'b0;
        void'($urandom(32'hA50929E0));
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(dio_pkg::OFS_STATUS_CMD, dio_pkg::RESP_OKAY, st(1'b0, 1'b0));
        busy_w <= 1'b1;
        repeat (5) @(posedge core_clk);
        rd(dio_pkg::OFS_STATUS_CMD, dio_pkg::RESP_OKAY, st(1'b0, 1'b1));
        p = 8'($urandom_range(1, 254));
        cmd(dio_pkg::OP_SET_POLARITY, p);
        cmd(dio_pkg::OP_GET_POLARITY, 8'h00);
        rd(dio_pkg::OFS_DATA_CLEAR, dio_pkg::RESP_OKAY, {24'h000000, p});
        x = 8'($urandom);
        cmd(dio_pkg::OP_SET_OUTPUT, x);
        chk("oc_on", {27'h0, x[6:0]}, {27'h0, oc_on});
        cmd(dio_pkg::OP_GET_OUTPUT, 8'h00);
        rd(dio_pkg::OFS_DATA_CLEAR, dio_pkg::RESP_OKAY, {25'h0000000, x[6:0]});
        x = 8'($urandom);
        settle(x);
        cmd(dio_pkg::OP_GET_RAW, 8'h00);
        rd(dio_pkg::OFS_DATA_CLEAR, dio_pkg::RESP_OKAY, {24'h000000, x});
        // Inputs held at the inactive level of every channel before clearing
        settle(p);
        cmd(dio_pkg::OP_CLR_LATCH, 8'h00);
        cmd(dio_pkg::OP_GET_LATCH, 8'h00);
        rd(dio_pkg::OFS_DATA_CLEAR, dio_pkg::RESP_OKAY, 32'h00000000);
        x = 8'($urandom_range(1, 255));
        settle(p ^ x);
        settle(p);
        cmd(dio_pkg::OP_GET_LATCH, 8'h00);
        rd(dio_pkg::OFS_DATA_CLEAR, dio_pkg::RESP_OKAY, {24'h000000, x});
        m = 8'($urandom);
        cmd(dio_pkg::OP_CLR_LATCH, m);
        cmd(dio_pkg::OP_GET_LATCH, 8'h00);
        rd(dio_pkg::OFS_DATA_CLEAR, dio_pkg::RESP_OKAY, {24'h000000, x & m});
        cmd(dio_pkg::OP_GET_POLARITY, 8'h00);
        rd(dio_pkg::OFS_STATUS_CMD, dio_pkg::RESP_OKAY, st(1'b1, 1'b1));
        wr(dio_pkg::OFS_DATA_CLEAR, 32'h00000000, dio_pkg::RESP_OKAY);
        rd(dio_pkg::OFS_STATUS_CMD, dio_pkg::RESP_OKAY, st(1'b0, 1'b1));
        rd(dio_pkg::OFS_DATA_CLEAR, dio_pkg::RESP_OKAY, 32'h00000000);
        rd(dio_pkg::OFS_IRQ_STATUS, dio_pkg::RESP_OKAY, 32'h00000003);
        wr(dio_pkg::OFS_IRQ_MASK, 32'h00000001, dio_pkg::RESP_OKAY);
        rd(dio_pkg::OFS_IRQ_MASK, dio_pkg::RESP_OKAY, 32'h00000001);
        cmd(dio_pkg::OP_CLR_LATCH, 8'h00);
        chk("irq", 34'h0, {33'h0, irq});
        settle(p ^ x);
        settle(p);
        chk("irq", 34'h1, {33'h0, irq});
        rd(dio_pkg::OFS_IRQ_STATUS, dio_pkg::RESP_OKAY, 32'h00000001);
        repeat (3) @(posedge core_clk);
        chk("irq", 34'h0, {33'h0, irq});
        // Masked event must not reach the interrupt line
        wr(dio_pkg::OFS_IRQ_MASK, 32'h00000000, dio_pkg::RESP_OKAY);
        cmd(dio_pkg::OP_CLR_LATCH, 8'h00);
        settle(p ^ x);
        chk("irq", 34'h0, {33'h0, irq});
        rd(8'h10, dio_pkg::RESP_SLVERR, 32'h00000000);
        wr(8'h20, 32'h0000FFFF, dio_pkg::RESP_SLVERR);
        // A mask write without byte strobes must leave the mask alone
        s_axi_wstrb <= 4'h0;
        wr(dio_pkg::OFS_IRQ_MASK, 32'h00000001, dio_pkg::RESP_OKAY);
        rd(dio_pkg::OFS_IRQ_MASK, dio_pkg::RESP_OKAY, 32'h00000000);
        repeat (4) @(posedge core_clk);
        test_done();
    end
endmodule
`default_nettype wire
